// ==== common/host_port_defines.svh ====
// Constants for the host register port
`ifndef HOST_PORT_DEFINES_SVH
`define HOST_PORT_DEFINES_SVH
`define HP_DATA_W 8
`define HP_BUS_W 32
`define HP_ADDR_W 8
`define HP_CFG_CYCLE_BIT 1
`define HP_CFG_POL_BIT 0
`define HP_ACCESS_CLKS 3'h5
`define HP_READY_LOW_CLK 3'h5
`define HP_CNT_RESET 3'h0
`endif

// ==== common/host_port_pkg.sv ====
// Types for the host register port
package host_port_pkg;
  typedef enum logic [1:0] {
    st_idle,
    st_fixed,
    st_var
  } port_state_type;
endpackage : host_port_pkg

// ==== verilog/host_register_port.sv ====
// Host processor register access port
// What this block does
// - Register data travels only on the lowest byte of the 32-bit host bus.
// - The upper 24 bus lines are never driven during register reads.
// - Config bit 1 high selects select-length cycles, low selects fixed cycles.
// - In variable mode read data is driven from the fifth clock while select stays low.
// - In variable mode releasing select frees the data lane and raises ready at once.
// - In variable mode the ready output is always driven.
// - In fixed mode each access lasts five clocks with read data only in the fifth.
// - In fixed mode ready is high for four clocks, low in the fifth, else released.
// - In fixed mode a new access may start right after the previous one ends.
// - Config bit 0 high makes direction an active-low write, low an active-high write.
`include "host_port_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module host_register_port #(
  parameter int ADDR_W = `HP_ADDR_W
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [1:0] host_port_config,
  input wire logic device_select_n,
  input wire logic dir_pin,
  input wire logic [ADDR_W-1:0] reg_addr_lines,
  input wire logic [`HP_BUS_W-1:0] bus_data_in,
  output logic [`HP_BUS_W-1:0] bus_data_out,
  output logic [`HP_BUS_W-1:0] bus_data_oe_n,
  output logic access_done_n,
  output logic access_done_oe_n,
  output logic [ADDR_W-1:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [`HP_DATA_W-1:0] reg_wdata,
  input wire logic [`HP_DATA_W-1:0] reg_rdata
);
  // Refuse address widths the port cannot carry
  if (ADDR_W < 1 || ADDR_W > 16) begin : g_bad_addr_w
    $error("ADDR_W out of range");
  end

  // Two-stage synchronisers for all pin inputs
  logic sel_s1_r, sel_s2_r, dir_s1_r, dir_s2_r;
  logic [1:0] cfg_s1_r, cfg_s2_r;
  logic [ADDR_W-1:0] adr_s1_r, adr_s2_r;
  logic [`HP_DATA_W-1:0] dat_s1_r, dat_s2_r;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sel_s1_r <= 1'b1;
      sel_s2_r <= 1'b1;
      dir_s1_r <= 1'b0;
      dir_s2_r <= 1'b0;
      cfg_s1_r <= 2'h0;
      cfg_s2_r <= 2'h0;
      adr_s1_r <= '0;
      adr_s2_r <= '0;
      dat_s1_r <= 8'h00;
      dat_s2_r <= 8'h00;
    end else begin
      sel_s1_r <= device_select_n;
      sel_s2_r <= sel_s1_r;
      dir_s1_r <= dir_pin;
      dir_s2_r <= dir_s1_r;
      cfg_s1_r <= host_port_config;
      cfg_s2_r <= cfg_s1_r;
      adr_s1_r <= reg_addr_lines;
      adr_s2_r <= adr_s1_r;
      dat_s1_r <= bus_data_in[`HP_DATA_W-1:0];
      dat_s2_r <= dat_s1_r;
    end
  end

  // Decode of mode and write polarity
  wire var_mode = cfg_s2_r[`HP_CFG_CYCLE_BIT];
  wire is_write = cfg_s2_r[`HP_CFG_POL_BIT] ? ~dir_s2_r : dir_s2_r;
  wire sel_act = ~sel_s2_r;

  host_port_pkg::port_state_type state_r, state_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic wr_r, drive_r, rdy_r, rdy_oe_n_r, wr_done_r;
  logic [`HP_DATA_W-1:0] rd_byte_r;

  wire last_fixed = (state_r == host_port_pkg::st_fixed) && (cnt_r == `HP_ACCESS_CLKS);
  wire start = sel_act && ((state_r == host_port_pkg::st_idle) || last_fixed);
  wire var_done = (state_r == host_port_pkg::st_var) && !sel_act;
  wire fifth = (cnt_nxt == `HP_READY_LOW_CLK);

  // Next-state selection
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    if (start) begin
      state_nxt = var_mode ? host_port_pkg::st_var : host_port_pkg::st_fixed;
      cnt_nxt = 3'h1;
    end else if (last_fixed || var_done) begin
      state_nxt = host_port_pkg::st_idle;
      cnt_nxt = `HP_CNT_RESET;
    end else if (state_r != host_port_pkg::st_idle && cnt_r != `HP_ACCESS_CLKS) begin
      cnt_nxt = cnt_r + 3'h1;
    end
  end

  // Access sequencer and output flops
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state_r <= host_port_pkg::st_idle;
      cnt_r <= `HP_CNT_RESET;
      wr_r <= 1'b0;
      drive_r <= 1'b0;
      rdy_r <= 1'b1;
      rdy_oe_n_r <= 1'b1;
      reg_addr <= '0;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      reg_wdata <= 8'h00;
      rd_byte_r <= 8'h00;
      wr_done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      reg_rd <= 1'b0;
      reg_wr <= 1'b0;
      if (start) begin
        reg_addr <= adr_s2_r;
        wr_r <= is_write;
        reg_rd <= !is_write;
        wr_done_r <= 1'b0;
      end
      if (cnt_nxt == 3'h4 && !wr_done_r && wr_r && state_nxt != host_port_pkg::st_idle) begin
        reg_wdata <= dat_s2_r;
        reg_wr <= 1'b1;
        wr_done_r <= 1'b1;
      end
      if (cnt_r == 3'h2) rd_byte_r <= reg_rdata;
      // Read data from the fifth clock; fixed only then, variable while selected
      drive_r <= (state_nxt != host_port_pkg::st_idle) && !wr_r && fifth && !start;
      if (state_nxt == host_port_pkg::st_var || var_mode) begin
        rdy_oe_n_r <= 1'b0;
        rdy_r <= !((state_nxt == host_port_pkg::st_var) && fifth && !start);
      end else begin
        rdy_oe_n_r <= (state_nxt == host_port_pkg::st_idle);
        rdy_r <= !(fifth && !start);
      end
    end
  end

  // Release is combinational on the raw select pin in variable mode
  wire var_release = var_mode && device_select_n;
  always_comb begin
    bus_data_out = {24'h000000, rd_byte_r};
    bus_data_oe_n = {24'hffffff, {`HP_DATA_W{~drive_r | var_release}}};
    access_done_n = rdy_r | var_release;
    access_done_oe_n = rdy_oe_n_r;
  end

  // Checks on lane release, ready timing and access sequencing
  property p_upper_free;
    @(posedge core_clk) disable iff (!nrst) bus_data_oe_n[31:8] == 24'hffffff;
  endproperty
  a_upper_free: assert property (p_upper_free) else $error("upper lanes driven");
  property p_fixed_len;
    @(posedge core_clk) disable iff (!nrst)
      $rose(state_r == host_port_pkg::st_fixed) |-> ##4 last_fixed;
  endproperty
  a_fixed_len: assert property (p_fixed_len) else $error("fixed access not 5 clocks");
  property p_fixed_rdy;
    @(posedge core_clk) disable iff (!nrst)
      last_fixed |-> !rdy_oe_n_r && !rdy_r;
  endproperty
  a_fixed_rdy: assert property (p_fixed_rdy) else $error("ready not low in fifth clock");
  property p_var_rdy_driven;
    @(posedge core_clk) disable iff (!nrst) var_mode && $past(var_mode) |-> !access_done_oe_n;
  endproperty
  a_var_rdy_driven: assert property (p_var_rdy_driven) else $error("ready released");
  property p_var_release;
    @(posedge core_clk) disable iff (!nrst)
      var_mode && device_select_n |-> access_done_n && bus_data_oe_n[7:0] == 8'hff;
  endproperty
  a_var_release: assert property (p_var_release) else $error("lane held after deselect");
  property p_drive_fifth;
    @(posedge core_clk) disable iff (!nrst) drive_r |-> cnt_r == 3'h5;
  endproperty
  a_drive_fifth: assert property (p_drive_fifth) else $error("read data early");
  property p_write_once;
    @(posedge core_clk) disable iff (!nrst) last_fixed && wr_r |-> wr_done_r;
  endproperty
  a_write_once: assert property (p_write_once) else $error("write not committed");
  property p_back_to_back;
    @(posedge core_clk) disable iff (!nrst)
      last_fixed && sel_act && !var_mode |=> state_r == host_port_pkg::st_fixed && cnt_r == 3'h1;
  endproperty
  a_back_to_back: assert property (p_back_to_back) else $error("back to back lost");
  property p_lane_fifth;
    @(posedge core_clk) disable iff (!nrst)
      !var_mode && bus_data_oe_n[7:0] != 8'hff |-> last_fixed;
  endproperty
  a_lane_fifth: assert property (p_lane_fifth) else $error("lane outside fifth");
  property p_var_hold;
    @(posedge core_clk) disable iff (!nrst)
      state_r == host_port_pkg::st_var && drive_r && sel_act |=> drive_r;
  endproperty
  a_var_hold: assert property (p_var_hold) else $error("read data dropped");
  property p_var_rdy_low;
    @(posedge core_clk) disable iff (!nrst)
      state_r == host_port_pkg::st_var && cnt_r == `HP_ACCESS_CLKS |-> !rdy_r && !rdy_oe_n_r;
  endproperty
  a_var_rdy_low: assert property (p_var_rdy_low) else $error("ready not low");
  property p_rdy_high;
    @(posedge core_clk) disable iff (!nrst)
      state_r == host_port_pkg::st_fixed && cnt_r != `HP_ACCESS_CLKS |->
        !access_done_oe_n && access_done_n;
  endproperty
  a_rdy_high: assert property (p_rdy_high) else $error("ready not high early");
  property p_rdy_off;
    @(posedge core_clk) disable iff (!nrst)
      state_r == host_port_pkg::st_idle && !var_mode && !$past(var_mode) |-> access_done_oe_n;
  endproperty
  a_rdy_off: assert property (p_rdy_off) else $error("ready driven when idle");
  property p_rd_strobe;
    @(posedge core_clk) disable iff (!nrst) start && !is_write |=> reg_rd;
  endproperty
  a_rd_strobe: assert property (p_rd_strobe) else $error("read strobe missing");
  property p_addr_take;
    @(posedge core_clk) disable iff (!nrst) start |=> reg_addr == $past(adr_s2_r);
  endproperty
  a_addr_take: assert property (p_addr_take) else $error("address not taken");
endmodule : host_register_port
`default_nettype wire

// ==== test/host_cpu_model.sv ====
// Host processor model that runs accesses on the register port pins
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model (
  input wire logic core_clk,
  input wire logic [31:0] bus_data_out,
  input wire logic [31:0] bus_data_oe_n,
  input wire logic access_done_n,
  input wire logic access_done_oe_n,
  output logic device_select_n = 1'b1,
  output logic dir_pin = 1'b0,
  output logic [7:0] reg_addr_lines = 8'h00,
  output logic [31:0] bus_data_in
);
  logic drv = 1'b0;
  logic [7:0] wd = 8'h00;
  // Lines follow the device, then host write data, else the pull-ups
  assign bus_data_in[31:8] = 24'hffffff;
  assign bus_data_in[7:0] = (~bus_data_oe_n[7:0] & bus_data_out[7:0]) |
    (bus_data_oe_n[7:0] & (drv ? wd : 8'hff));
  // Fixed mode pulses select, variable mode holds it past ready
  task automatic access(input logic vm, input logic pol, input logic wr, input logic [7:0] a,
      input logic [7:0] d, output logic [31:0] q, output logic [7:0] q2, output int hi,
      output logic rel);
    q = 32'h0;
    q2 = 8'h00;
    hi = 0;
    rel = 1'b0;
    @(posedge core_clk);
    device_select_n <= 1'b0;
    dir_pin <= wr ^ pol;
    reg_addr_lines <= a;
    wd <= d;
    drv <= wr;
    if (!vm) begin
      @(posedge core_clk);
      device_select_n <= 1'b1;
    end
    for (int i = 0; i < 20 && q == 32'h0; i++) begin
      @(negedge core_clk);
      if (access_done_n === 1'b0) q = {bus_data_oe_n[31:8], bus_data_in[7:0]};
      else if (access_done_oe_n === 1'b0) hi++;
    end
    if (q == 32'h0) hi = -1;
    if (vm) begin
      repeat (2) @(negedge core_clk);
      q2 = bus_data_in[7:0];
      @(posedge core_clk);
      device_select_n <= 1'b1;
      drv <= 1'b0;
      #1 rel = bus_data_oe_n[7:0] === 8'hff && access_done_n === 1'b1;
      repeat (2) @(posedge core_clk);
    end else begin
      @(posedge core_clk);
      drv <= 1'b0;
      @(negedge core_clk);
      rel = bus_data_oe_n[7:0] === 8'hff;
    end
  endtask : access
  // Two fixed reads, the second select timed to start in the first's last clock
  task automatic fixed_pair(input logic pol, input logic [7:0] a0, input logic [7:0] a1,
      output logic [7:0] r0, output logic [7:0] r1, output int gap);
    int t0;
    t0 = 0;
    r0 = 8'h00;
    r1 = 8'h00;
    gap = -1;
    @(posedge core_clk);
    device_select_n <= 1'b0;
    dir_pin <= pol;
    reg_addr_lines <= a0;
    @(posedge core_clk);
    device_select_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    device_select_n <= 1'b0;
    reg_addr_lines <= a1;
    @(posedge core_clk);
    device_select_n <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      @(negedge core_clk);
      if (access_done_n === 1'b0 && gap < 0) begin
        if (t0 == 0) begin
          r0 = bus_data_in[7:0];
          t0 = i + 1;
        end else begin
          r1 = bus_data_in[7:0];
          gap = i + 1 - t0;
        end
      end
    end
  endtask : fixed_pair
endmodule : host_cpu_model
`default_nettype wire

// ==== test/host_register_port_tb.sv ====
// Self-checking bench for the host register port
`timescale 1ns/1ps
`default_nettype none
module host_register_port_tb;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] host_port_config = 2'h0;
  logic device_select_n, dir_pin, access_done_n, access_done_oe_n, reg_wr, reg_rd, rel;
  logic [7:0] reg_addr_lines, reg_addr, reg_wdata, reg_rdata, q2;
  logic [31:0] bus_data_in, bus_data_out, bus_data_oe_n, q;
  logic [7:0] regs [256];
  int failures = 0;
  int n_tests = 0;
  int hi;
  int n_rd = 0;
  always #2.5 core_clk = ~core_clk;
  // Register file behind the port
  assign reg_rdata = regs[reg_addr];
  always @(posedge core_clk) if (reg_wr) regs[reg_addr] <= reg_wdata;
  // Count read strobes seen by the register file
  always @(posedge core_clk) if (reg_rd) n_rd++;
  host_register_port u_host_register_port (.core_clk(core_clk), .nrst(nrst),
    .host_port_config(host_port_config), .device_select_n(device_select_n),
    .dir_pin(dir_pin), .reg_addr_lines(reg_addr_lines), .bus_data_in(bus_data_in),
    .bus_data_out(bus_data_out), .bus_data_oe_n(bus_data_oe_n), .access_done_n(access_done_n),
    .access_done_oe_n(access_done_oe_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  host_cpu_model u_host_cpu_model (.core_clk(core_clk), .bus_data_out(bus_data_out),
    .bus_data_oe_n(bus_data_oe_n), .access_done_n(access_done_n),
    .access_done_oe_n(access_done_oe_n), .device_select_n(device_select_n),
    .dir_pin(dir_pin), .reg_addr_lines(reg_addr_lines), .bus_data_in(bus_data_in));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks=%0d failures=%0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  // One access; a lost ready ends the run
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
    u_host_cpu_model.access(host_port_config[1], host_port_config[0], wr, a, d, q, q2, hi, rel);
    if (hi < 0) begin
      failures++;
      print_verdict();
    end
  endtask : xfer
  // Change the strap pins and let them settle
  task automatic set_cfg(input logic [1:0] c);
    @(posedge core_clk);
    host_port_config <= c;
    repeat (4) @(negedge core_clk);
    check(access_done_oe_n, {31'h0, ~c[1]});
  endtask : set_cfg
  // Write then read back per mode and polarity
  task automatic test_modes(input logic vm);
    for (int p = 0; p < 2; p++) begin
      set_cfg({vm, p[0]});
      xfer(1'b1, 8'h3c + 8'(p), 8'ha5 ^ 8'(p));
      check(rel, 1'b1);
      xfer(1'b0, 8'h3c + 8'(p), 8'h00);
      check(q, {24'hffffff, 8'ha5 ^ 8'(p)});
      check(rel, 1'b1);
      if (vm) check(q2, 8'ha5 ^ 8'(p));
      else check(hi, 4);
    end
    $display("test_modes %0d done", vm);
  endtask : test_modes
  // Back-to-back fixed reads with no idle clock between them
  task automatic test_back_to_back();
    logic [7:0] r0, r1;
    int gap;
    int rd0;
    set_cfg(2'h0);
    xfer(1'b1, 8'h51, 8'h5a);
    xfer(1'b1, 8'h52, 8'hc3);
    rd0 = n_rd;
    u_host_cpu_model.fixed_pair(1'b0, 8'h51, 8'h52, r0, r1, gap);
    check(r0, 8'h5a);
    check(r1, 8'hc3);
    check(gap, 5);
    check(n_rd - rd0, 2);
    $display("test_back_to_back done");
  endtask : test_back_to_back
  initial begin
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    @(negedge core_clk);
    check(bus_data_oe_n, 32'hffffffff);
    test_modes(1'b0);
    test_back_to_back();
    test_modes(1'b1);
    print_verdict();
  end
endmodule : host_register_port_tb
`default_nettype wire
